// *** bwu_apb_master.sv ***
// APB master standing in for debug software and the external debugger
`timescale 1ns/1ps
module bwu_apb_master (
  input wire logic sys_clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    {psel, penable, pwrite} = 3'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end

  // Call right after a rising edge; holds until pready seen
  task automatic xfer(input logic wr, input logic [7:0] idx,
      input logic [31:0] wd, output logic [31:0] rd, output logic err);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'h1;
    do @(posedge sys_clk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
endmodule // bwu_apb_master

// *** bwu_defs.svh ***
// Offsets, field positions, reset values and codes of the watch unit
`ifndef BWU_DEFS_SVH
`define BWU_DEFS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define BWU_IDX_HIT_INFO 8'h16
`define BWU_IDX_HALT_MASK 8'h18
`define BWU_IDX_MAILBOX 8'h20
`define BWU_IDX_IB_ADDR 8'h30
`define BWU_IDX_IB_CTRL 8'h40
`define BWU_IDX_DW_ADDR1 8'h50
`define BWU_IDX_DW_ADDR2 8'h60
`define BWU_IDX_DW_CTRL 8'h70
`define BWU_IDX_RW_MASK 8'h80
`define BWU_IDX_RW_VALUE 8'h90
`define BWU_IDX_RW_CTRL 8'h9c

// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define BWU_CTRL_EN_BIT 0
`define BWU_CTRL_SEL_BIT 1
`define BWU_CTRL_LOAD_BIT 2
`define BWU_CTRL_TMASK_LSB 16
`define BWU_CTRL_TMASK_MSB 23
`define BWU_IB_CTRL_WMASK 32'h00ff0003
`define BWU_DW_CTRL_WMASK 32'h00ff0007
`define BWU_RW_CTRL_WMASK 32'h00ff0003
`define BWU_HALT_WMASK 32'h000000ff

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define BWU_RST_WORD 32'h00000000
`define BWU_RST_CTRL 32'h00000000
`define BWU_RST_HALT 8'h00

// ----------------------------------------------------------------
// Cause codes
// ----------------------------------------------------------------
`define BWU_CAUSE_NONE 3'h0
`define BWU_CAUSE_IBP 3'h3
`define BWU_CAUSE_DWP 3'h4
`define BWU_CAUSE_RWP 3'h5

`endif

// *** bwu_pkg.sv ***
// Types shared by the watch unit files
package bwu_pkg;

  typedef logic [31:0] bwu_word_t;
  typedef logic [7:0] bwu_tmask_t;
  typedef logic [2:0] bwu_thread_t;
  typedef logic [1:0] bwu_slot_t;

  typedef enum logic [2:0] {
    BWU_NONE = 3'b000,
    BWU_IBP = 3'b011,
    BWU_DWP = 3'b100,
    BWU_RWP = 3'b101
  } bwu_cause_t;

endpackage

// *** bwu_tb_top.sv ***
// Self-checking bench for the breakpoint and watchpoint unit
`timescale 1ns/1ps
module bwu_tb_top;
  import bwu_pkg::*;
  typedef struct {logic [7:0] idx; bwu_word_t wd; bwu_word_t rd; logic err;}
    bwu_row_t;
  logic sys_clk = 1'h0;
  logic nrst = 1'h0;
  logic psel, penable, pwrite, pready, pslverr, pc_valid, mem_valid;
  logic mem_is_load, res_valid, in_debug_mode, cfg_scratch_wr, debug_irq, e;
  logic [11:0] paddr;
  logic [2:0] cfg_scratch_sel;
  bwu_word_t pwdata, prdata, pc_value, mem_addr, res_id, d;
  bwu_word_t cfg_scratch_wdata, cfg_scratch_rdata;
  bwu_thread_t pc_thread, mem_thread, res_thread, cause_thread;
  bwu_cause_t interrupt_cause_code;
  bwu_slot_t cause_index;
  bwu_tmask_t halted_thread_bits;
  int err_count = 0;
  int n_tests = 0;
  bwu_row_t rows [12] = '{
    '{8'h16, 32'hdeadbeef, 32'hdeadbeef, 1'h0},
    '{8'h18, 32'hffffffff, 32'h000000ff, 1'h0},
    '{8'h27, 32'h12345678, 32'h12345678, 1'h0},
    '{8'h33, 32'h89abcdef, 32'h89abcdef, 1'h0},
    '{8'h43, 32'hffffffff, 32'h00ff0003, 1'h0},
    '{8'h53, 32'h0f0f0f0f, 32'h0f0f0f0f, 1'h0},
    '{8'h60, 32'hf0f0f0f0, 32'hf0f0f0f0, 1'h0},
    '{8'h73, 32'hffffffff, 32'h00ff0007, 1'h0},
    '{8'h83, 32'h00ff00ff, 32'h00ff00ff, 1'h0},
    '{8'h9f, 32'hffffffff, 32'h00ff0003, 1'h0},
    '{8'h17, 32'hffffffff, 32'h00000000, 1'h1},
    '{8'h44, 32'hffffffff, 32'h00000000, 1'h1}};

  always #2.5 sys_clk = ~sys_clk;

  bwu_top dut_u (.sys_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .pc_valid, .pc_value, .pc_thread, .mem_valid,
    .mem_is_load, .mem_addr, .mem_thread, .res_valid, .res_id, .res_thread,
    .in_debug_mode, .cfg_scratch_wr, .cfg_scratch_sel, .cfg_scratch_wdata,
    .cfg_scratch_rdata, .debug_irq, .interrupt_cause_code, .cause_index,
    .cause_thread, .halted_thread_bits);
  bwu_apb_master mst_u (.sys_clk, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr);

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk_word(input string nm, input logic [31:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    @(posedge sys_clk);
    mst_u.xfer(1'h1, idx, wd, d, e);
  endtask

  task automatic rchk(input string nm, input logic [7:0] idx,
      input logic [31:0] exp);
    @(posedge sys_clk);
    mst_u.xfer(1'h0, idx, 32'h0, d, e);
    chk_word(nm, exp, d);
  endtask

  task automatic do_reset();
    nrst <= 1'h0;
    repeat (20) @(posedge sys_clk);
    nrst <= 1'h1;
  endtask

  // One sample of kind k (0 pc, 1 memory, 2 resource), then outcome
  task automatic hit(input int k, input logic [31:0] v, input bwu_thread_t t,
      input logic ld, input logic irq, input bwu_cause_t c,
      input bwu_slot_t i);
    @(posedge sys_clk);
    pc_valid <= (k == 0);
    mem_valid <= (k == 1);
    res_valid <= (k == 2);
    {pc_value, mem_addr, res_id} <= {v, v, v};
    {pc_thread, mem_thread, res_thread} <= {t, t, t};
    mem_is_load <= ld;
    @(posedge sys_clk);
    {pc_valid, mem_valid, res_valid} <= 3'h0;
    @(negedge sys_clk);
    chk_word("irq", {31'h0, irq}, {31'h0, debug_irq});
    if (irq) begin
      chk_word("cause", {29'h0, c}, {29'h0, interrupt_cause_code});
      chk_word("index", {30'h0, i}, {30'h0, cause_index});
      chk_word("thread", {29'h0, t}, {29'h0, cause_thread});
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge sys_clk);
    err_count++;
    tally_and_finish();
  end

  initial begin
    {pc_valid, mem_valid, res_valid, mem_is_load} = 4'h0;
    {pc_value, mem_addr, res_id, cfg_scratch_wdata} = 128'h0;
    {pc_thread, mem_thread, res_thread, cfg_scratch_sel} = 12'h0;
    {in_debug_mode, cfg_scratch_wr} = 2'h0;
    do_reset();
    foreach (rows[n]) begin
      wr(rows[n].idx, rows[n].wd);
      rchk("table read", rows[n].idx, rows[n].rd);
      chk_word("table error", {31'h0, rows[n].err}, {31'h0, e});
    end
    do_reset();
    rchk("ib ctrl rst", 8'h43, 32'h0);
    rchk("dw ctrl rst", 8'h73, 32'h0);
    rchk("halt rst", 8'h18, 32'h0);
    // ----------------------------------------------------------------
    // Trigger cases
    // ----------------------------------------------------------------
    wr(8'h31, 32'h00001000);
    wr(8'h41, 32'h00040001);
    hit(0, 32'h1000, 3'h2, 1'h0, 1'h1, BWU_IBP, 2'h1);
    hit(0, 32'h1000, 3'h3, 1'h0, 1'h0, BWU_NONE, 2'h0);
    hit(0, 32'h1004, 3'h2, 1'h0, 1'h0, BWU_NONE, 2'h0);
    wr(8'h41, 32'h00040003);
    hit(0, 32'h1004, 3'h2, 1'h0, 1'h1, BWU_IBP, 2'h1);
    hit(0, 32'h1000, 3'h2, 1'h0, 1'h0, BWU_NONE, 2'h0);
    wr(8'h41, 32'h00000000);
    hit(0, 32'h1004, 3'h2, 1'h0, 1'h0, BWU_NONE, 2'h0);
    wr(8'h50, 32'h00000100);
    wr(8'h60, 32'h000001ff);
    wr(8'h52, 32'h00000100);
    wr(8'h62, 32'h000001ff);
    wr(8'h70, 32'h00ff0001);
    wr(8'h72, 32'h00ff0001);
    hit(1, 32'h180, 3'h5, 1'h0, 1'h1, BWU_DWP, 2'h0);
    rchk("hit info data", 8'h16, 32'h180);
    hit(1, 32'h200, 3'h5, 1'h0, 1'h0, BWU_NONE, 2'h0);
    hit(1, 32'h0ff, 3'h5, 1'h0, 1'h0, BWU_NONE, 2'h0);
    hit(1, 32'h180, 3'h5, 1'h1, 1'h0, BWU_NONE, 2'h0);
    wr(8'h70, 32'h00ff0005);
    hit(1, 32'h1ff, 3'h5, 1'h1, 1'h1, BWU_DWP, 2'h0);
    wr(8'h70, 32'h00ff0003);
    hit(1, 32'h300, 3'h5, 1'h0, 1'h1, BWU_DWP, 2'h0);
    wr(8'h70, 32'h00000000);
    hit(1, 32'h100, 3'h6, 1'h0, 1'h1, BWU_DWP, 2'h2);
    wr(8'h72, 32'h00000000);
    wr(8'h83, 32'h000000ff);
    wr(8'h93, 32'h00000042);
    wr(8'h9f, 32'h00ff0001);
    hit(2, 32'h1242, 3'h1, 1'h0, 1'h1, BWU_RWP, 2'h3);
    rchk("hit info res", 8'h16, 32'h1242);
    hit(2, 32'h43, 3'h1, 1'h0, 1'h0, BWU_NONE, 2'h0);
    wr(8'h9f, 32'h00ff0003);
    hit(2, 32'h43, 3'h1, 1'h0, 1'h1, BWU_RWP, 2'h3);
    // ----------------------------------------------------------------
    // Halt mask and shared scratch
    // ----------------------------------------------------------------
    wr(8'h18, 32'h000000a5);
    repeat (2) @(posedge sys_clk);
    chk_word("halt", 32'ha5, {24'h0, halted_thread_bits});
    in_debug_mode <= 1'h1;
    hit(2, 32'h43, 3'h1, 1'h0, 1'h0, BWU_NONE, 2'h0);
    chk_word("halt dbg", 32'h0, {24'h0, halted_thread_bits});
    @(posedge sys_clk);
    in_debug_mode <= 1'h0;
    cfg_scratch_wr <= 1'h1;
    cfg_scratch_sel <= 3'h5;
    cfg_scratch_wdata <= 32'h5555aaaa;
    @(posedge sys_clk);
    cfg_scratch_wr <= 1'h0;
    rchk("scratch apb", 8'h25, 32'h5555aaaa);
    chk_word("halt ret", 32'ha5, {24'h0, halted_thread_bits});
    wr(8'h23, 32'hcafe0123);
    @(posedge sys_clk);
    cfg_scratch_sel <= 3'h3;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    chk_word("scratch cfg", 32'hcafe0123, cfg_scratch_rdata);
    tally_and_finish();
  end
endmodule // bwu_tb_top

// *** bwu_top.sv ***
// Breakpoint and watchpoint unit with APB register slave
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`include "bwu_defs.svh"

// Summary of operation
// - Data hit loads access address into info
// - Resource hit loads resource id into info
// - Masked threads stay halted after debug return
// - Eight-bit halt mask, active outside debug
// - Eight scratch words shared with config port
// - Enabled breakpoint compares PC, raises interrupt
// - Four instruction breakpoints, own registers each
// - Bits 23:16 gate triggering per thread
// - Bit 1 selects equal or differ
// - Bit 0 enables comparator, reset clear
// - Two address registers per data watchpoint
// - Bit 2 adds loads to data watch
// - Bit 1 combines data conditions AND/OR
// - Mask and value per resource watchpoint
// - Bit 1 picks resource condition A or B
// - Cause code 3, 4 or 5
// - Lowest-numbered simultaneous trigger is reported
module bwu_top (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire bwu_pkg::bwu_word_t pwdata,
  output bwu_pkg::bwu_word_t prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pc_valid,
  input wire bwu_pkg::bwu_word_t pc_value,
  input wire bwu_pkg::bwu_thread_t pc_thread,
  input wire logic mem_valid,
  input wire logic mem_is_load,
  input wire bwu_pkg::bwu_word_t mem_addr,
  input wire bwu_pkg::bwu_thread_t mem_thread,
  input wire logic res_valid,
  input wire bwu_pkg::bwu_word_t res_id,
  input wire bwu_pkg::bwu_thread_t res_thread,
  input wire logic in_debug_mode,
  input wire logic cfg_scratch_wr,
  input wire logic [2:0] cfg_scratch_sel,
  input wire bwu_pkg::bwu_word_t cfg_scratch_wdata,
  output bwu_pkg::bwu_word_t cfg_scratch_rdata,
  output logic debug_irq,
  output bwu_pkg::bwu_cause_t interrupt_cause_code,
  output bwu_pkg::bwu_slot_t cause_index,
  output bwu_pkg::bwu_thread_t cause_thread,
  output bwu_pkg::bwu_tmask_t halted_thread_bits
);
  import bwu_pkg::*;

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  bwu_word_t watch_hit_info;
  bwu_tmask_t core_halt_mask;
  bwu_word_t debugger_mailbox_words [8];
  bwu_word_t instr_bp_address [4];
  bwu_word_t instr_bp_control [4];
  bwu_word_t data_wp_first_address [4];
  bwu_word_t data_wp_second_address [4];
  bwu_word_t data_wp_control [4];
  bwu_word_t res_wp_mask [4];
  bwu_word_t res_wp_value [4];
  bwu_word_t res_wp_control [4];

  logic [7:0] reg_idx;
  logic addr_ok;
  logic apb_write;
  bwu_word_t next_rdata;
  logic next_err;
  logic [3:0] ib_hit;
  logic [3:0] dw_hit;
  logic [3:0] rw_hit;
  logic fire;
  bwu_cause_t next_cause;
  bwu_slot_t next_index;
  bwu_thread_t next_thread;
  logic info_load;
  bwu_word_t next_info;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign reg_idx = paddr[9:2];
  assign addr_ok = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00);
  // A write lands only at the edge where the access completes
  assign apb_write = psel & penable & pready & pwrite & ~pslverr;

  function automatic logic idx_in(input logic [7:0] idx,
                                  input logic [7:0] base,
                                  input logic [7:0] count);
    idx_in = (idx >= base) && (idx < base + count);
  endfunction

  function automatic logic [1:0] low_slot(input logic [3:0] hits);
    low_slot = 2'd0;
    for (int k = 3; k >= 0; k--) begin
      if (hits[k]) begin
        low_slot = 2'(k);
      end
    end
  endfunction

  always_comb begin
    logic [7:0] off;
    off = 8'h00;
    next_rdata = `BWU_RST_WORD;
    next_err = 1'b0;
    if (!addr_ok) begin
      next_err = 1'b1;
    end else if (reg_idx == `BWU_IDX_HIT_INFO) begin
      next_rdata = watch_hit_info;
    end else if (reg_idx == `BWU_IDX_HALT_MASK) begin
      next_rdata = {24'h000000, core_halt_mask};
    end else if (idx_in(reg_idx, `BWU_IDX_MAILBOX, 8'h08)) begin
      off = reg_idx - `BWU_IDX_MAILBOX;
      next_rdata = debugger_mailbox_words[off[2:0]];
    end else if (idx_in(reg_idx, `BWU_IDX_IB_ADDR, 8'h04)) begin
      off = reg_idx - `BWU_IDX_IB_ADDR;
      next_rdata = instr_bp_address[off[1:0]];
    end else if (idx_in(reg_idx, `BWU_IDX_IB_CTRL, 8'h04)) begin
      off = reg_idx - `BWU_IDX_IB_CTRL;
      next_rdata = instr_bp_control[off[1:0]];
    end else if (idx_in(reg_idx, `BWU_IDX_DW_ADDR1, 8'h04)) begin
      off = reg_idx - `BWU_IDX_DW_ADDR1;
      next_rdata = data_wp_first_address[off[1:0]];
    end else if (idx_in(reg_idx, `BWU_IDX_DW_ADDR2, 8'h04)) begin
      off = reg_idx - `BWU_IDX_DW_ADDR2;
      next_rdata = data_wp_second_address[off[1:0]];
    end else if (idx_in(reg_idx, `BWU_IDX_DW_CTRL, 8'h04)) begin
      off = reg_idx - `BWU_IDX_DW_CTRL;
      next_rdata = data_wp_control[off[1:0]];
    end else if (idx_in(reg_idx, `BWU_IDX_RW_MASK, 8'h04)) begin
      off = reg_idx - `BWU_IDX_RW_MASK;
      next_rdata = res_wp_mask[off[1:0]];
    end else if (idx_in(reg_idx, `BWU_IDX_RW_VALUE, 8'h04)) begin
      off = reg_idx - `BWU_IDX_RW_VALUE;
      next_rdata = res_wp_value[off[1:0]];
    end else if (idx_in(reg_idx, `BWU_IDX_RW_CTRL, 8'h04)) begin
      off = reg_idx - `BWU_IDX_RW_CTRL;
      next_rdata = res_wp_control[off[1:0]];
    end else begin
      next_err = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // APB answer: ready in the first cycle of the access phase
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= `BWU_RST_WORD;
    end else if (psel && !penable) begin
      pready <= 1'b1;
      pslverr <= next_err;
      prdata <= pwrite ? `BWU_RST_WORD : next_rdata;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= `BWU_RST_WORD;
    end
  end

  // ----------------------------------------------------------------
  // Comparator registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 4; i++) begin
        instr_bp_address[i] <= `BWU_RST_WORD;
        instr_bp_control[i] <= `BWU_RST_CTRL;
        data_wp_first_address[i] <= `BWU_RST_WORD;
        data_wp_second_address[i] <= `BWU_RST_WORD;
        data_wp_control[i] <= `BWU_RST_CTRL;
        res_wp_mask[i] <= `BWU_RST_WORD;
        res_wp_value[i] <= `BWU_RST_WORD;
        res_wp_control[i] <= `BWU_RST_CTRL;
      end
    end else if (apb_write) begin
      for (int i = 0; i < 4; i++) begin
        if (reg_idx == `BWU_IDX_IB_ADDR + 8'(i)) begin
          instr_bp_address[i] <= pwdata;
        end
        if (reg_idx == `BWU_IDX_IB_CTRL + 8'(i)) begin
          instr_bp_control[i] <= pwdata & `BWU_IB_CTRL_WMASK;
        end
        if (reg_idx == `BWU_IDX_DW_ADDR1 + 8'(i)) begin
          data_wp_first_address[i] <= pwdata;
        end
        if (reg_idx == `BWU_IDX_DW_ADDR2 + 8'(i)) begin
          data_wp_second_address[i] <= pwdata;
        end
        if (reg_idx == `BWU_IDX_DW_CTRL + 8'(i)) begin
          data_wp_control[i] <= pwdata & `BWU_DW_CTRL_WMASK;
        end
        if (reg_idx == `BWU_IDX_RW_MASK + 8'(i)) begin
          res_wp_mask[i] <= pwdata;
        end
        if (reg_idx == `BWU_IDX_RW_VALUE + 8'(i)) begin
          res_wp_value[i] <= pwdata;
        end
        if (reg_idx == `BWU_IDX_RW_CTRL + 8'(i)) begin
          res_wp_control[i] <= pwdata & `BWU_RW_CTRL_WMASK;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Shared scratch words; APB wins a same-word collision
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 8; i++) begin
        debugger_mailbox_words[i] <= `BWU_RST_WORD;
      end
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (apb_write && reg_idx == `BWU_IDX_MAILBOX + 8'(i)) begin
          debugger_mailbox_words[i] <= pwdata;
        end else if (cfg_scratch_wr && cfg_scratch_sel == 3'(i)) begin
          debugger_mailbox_words[i] <= cfg_scratch_wdata;
        end
      end
    end
  end

  // Config-side read returns the word as stored before this edge
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cfg_scratch_rdata <= `BWU_RST_WORD;
    end else begin
      cfg_scratch_rdata <= debugger_mailbox_words[cfg_scratch_sel];
    end
  end

  // ----------------------------------------------------------------
  // Halt mask and thread stop outputs
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      core_halt_mask <= `BWU_RST_HALT;
    end else if (apb_write && reg_idx == `BWU_IDX_HALT_MASK) begin
      core_halt_mask <= pwdata[7:0];
    end
  end

  // Stops apply only outside debug mode, so they bite on return
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      halted_thread_bits <= `BWU_RST_HALT;
    end else if (in_debug_mode) begin
      halted_thread_bits <= `BWU_RST_HALT;
    end else begin
      halted_thread_bits <= core_halt_mask;
    end
  end

  // ----------------------------------------------------------------
  // Comparator slots
  // ----------------------------------------------------------------
  for (genvar g = 0; g < 4; g++) begin : g_slot
    bwu_watch_slot u_slot (
      .ib_addr(instr_bp_address[g]),
      .ib_ctrl(instr_bp_control[g]),
      .dw_addr1(data_wp_first_address[g]),
      .dw_addr2(data_wp_second_address[g]),
      .dw_ctrl(data_wp_control[g]),
      .rw_mask(res_wp_mask[g]),
      .rw_value(res_wp_value[g]),
      .rw_ctrl(res_wp_control[g]),
      .pc_valid(pc_valid),
      .pc_value(pc_value),
      .pc_thread(pc_thread),
      .mem_valid(mem_valid),
      .mem_is_load(mem_is_load),
      .mem_addr(mem_addr),
      .mem_thread(mem_thread),
      .res_valid(res_valid),
      .res_id(res_id),
      .res_thread(res_thread),
      .ib_hit(ib_hit[g]),
      .dw_hit(dw_hit[g]),
      .rw_hit(rw_hit[g])
    );
  end

  // ----------------------------------------------------------------
  // Trigger priority: instruction, then data, then resource
  // ----------------------------------------------------------------
  always_comb begin
    next_cause = BWU_NONE;
    next_index = 2'd0;
    next_thread = 3'd0;
    info_load = 1'b0;
    next_info = `BWU_RST_WORD;
    if (|ib_hit) begin
      next_cause = BWU_IBP;
      next_index = low_slot(ib_hit);
      next_thread = pc_thread;
    end else if (|dw_hit) begin
      next_cause = BWU_DWP;
      next_index = low_slot(dw_hit);
      next_thread = mem_thread;
      info_load = 1'b1;
      next_info = mem_addr;
    end else if (|rw_hit) begin
      next_cause = BWU_RWP;
      next_index = low_slot(rw_hit);
      next_thread = res_thread;
      info_load = 1'b1;
      next_info = res_id;
    end
  end

  // No new trigger while the handler is already running
  assign fire = ~in_debug_mode & (next_cause != BWU_NONE);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      debug_irq <= 1'b0;
    end else begin
      debug_irq <= fire;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      interrupt_cause_code <= BWU_NONE;
      cause_index <= 2'd0;
      cause_thread <= 3'd0;
    end else if (fire) begin
      interrupt_cause_code <= next_cause;
      cause_index <= next_index;
      cause_thread <= next_thread;
    end
  end

  // Hardware capture wins over a software write in the same cycle
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      watch_hit_info <= `BWU_RST_WORD;
    end else if (fire && info_load) begin
      watch_hit_info <= next_info;
    end else if (apb_write && reg_idx == `BWU_IDX_HIT_INFO) begin
      watch_hit_info <= pwdata;
    end
  end

endmodule // bwu_top

// *** bwu_top_assertions.sv ***
// Port-level checker for the watch unit, bound to its top module
`timescale 1ns/1ps
module bwu_checker (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire bwu_pkg::bwu_word_t prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic pc_valid,
  input wire logic mem_valid,
  input wire logic res_valid,
  input wire logic in_debug_mode,
  input wire logic cfg_scratch_wr,
  input wire logic [2:0] cfg_scratch_sel,
  input wire bwu_pkg::bwu_word_t cfg_scratch_wdata,
  input wire bwu_pkg::bwu_word_t cfg_scratch_rdata,
  input wire logic debug_irq,
  input wire bwu_pkg::bwu_cause_t interrupt_cause_code,
  input wire bwu_pkg::bwu_tmask_t halted_thread_bits
);
  import bwu_pkg::*;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  sequence cfg_wr_s;
    cfg_scratch_wr && !psel ##1 !psel && $stable(cfg_scratch_sel);
  endsequence
  sequence halt_quiet_s;
    (!psel && !in_debug_mode) [*3];
  endsequence

  apb_answer_a: assert property ((psel && !penable) |=> pready ##1 !pready)
    else $error("pready not a single cycle after setup");
  apb_err_a: assert property (pslverr |-> pready && psel && penable)
    else $error("pslverr outside an access cycle");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata nonzero without pready");
  scratch_cfg_a: assert property (
    cfg_wr_s |=> cfg_scratch_rdata == $past(cfg_scratch_wdata, 2))
    else $error("config scratch write not read back");
  halt_debug_a: assert property (
    in_debug_mode |=> halted_thread_bits == 8'h00)
    else $error("threads held while in debug mode");
  halt_steady_a: assert property (
    halt_quiet_s |-> $stable(halted_thread_bits))
    else $error("halt bits moved with no write");
  no_sample_a: assert property (
    !(pc_valid || mem_valid || res_valid) || in_debug_mode |=> !debug_irq)
    else $error("debug irq without a live sample");
  irq_code_a: assert property (
    debug_irq |-> interrupt_cause_code inside {BWU_IBP, BWU_DWP, BWU_RWP})
    else $error("bad cause code with debug irq");
  no_pc_code_a: assert property (
    !pc_valid ##1 debug_irq |-> interrupt_cause_code != BWU_IBP)
    else $error("instruction cause without pc sample");
  res_only_a: assert property (
    !pc_valid && !mem_valid ##1 debug_irq |-> interrupt_cause_code == BWU_RWP)
    else $error("resource hit with wrong cause");
endmodule // bwu_checker

bind bwu_top bwu_checker chk_u (
  .sys_clk, .nrst, .psel, .penable, .prdata, .pready, .pslverr,
  .pc_valid, .mem_valid, .res_valid, .in_debug_mode, .cfg_scratch_wr,
  .cfg_scratch_sel, .cfg_scratch_wdata, .cfg_scratch_rdata, .debug_irq,
  .interrupt_cause_code, .halted_thread_bits
);

// *** bwu_watch_slot.sv ***
// One comparator slot: instruction, data and resource match logic
`timescale 1ns/1ps
`include "bwu_defs.svh"

module bwu_watch_slot (
  input wire bwu_pkg::bwu_word_t ib_addr,
  input wire bwu_pkg::bwu_word_t ib_ctrl,
  input wire bwu_pkg::bwu_word_t dw_addr1,
  input wire bwu_pkg::bwu_word_t dw_addr2,
  input wire bwu_pkg::bwu_word_t dw_ctrl,
  input wire bwu_pkg::bwu_word_t rw_mask,
  input wire bwu_pkg::bwu_word_t rw_value,
  input wire bwu_pkg::bwu_word_t rw_ctrl,
  input wire logic pc_valid,
  input wire bwu_pkg::bwu_word_t pc_value,
  input wire bwu_pkg::bwu_thread_t pc_thread,
  input wire logic mem_valid,
  input wire logic mem_is_load,
  input wire bwu_pkg::bwu_word_t mem_addr,
  input wire bwu_pkg::bwu_thread_t mem_thread,
  input wire logic res_valid,
  input wire bwu_pkg::bwu_word_t res_id,
  input wire bwu_pkg::bwu_thread_t res_thread,
  output logic ib_hit,
  output logic dw_hit,
  output logic rw_hit
);
  import bwu_pkg::*;

  bwu_tmask_t ib_tmask;
  bwu_tmask_t dw_tmask;
  bwu_tmask_t rw_tmask;
  logic pc_equal;
  logic ib_cond;
  logic dw_cond_a;
  logic dw_cond_b;
  logic dw_cond;
  logic dw_kind_ok;
  bwu_word_t res_masked;
  logic rw_cond;

  assign ib_tmask = ib_ctrl[`BWU_CTRL_TMASK_MSB:`BWU_CTRL_TMASK_LSB];
  assign dw_tmask = dw_ctrl[`BWU_CTRL_TMASK_MSB:`BWU_CTRL_TMASK_LSB];
  assign rw_tmask = rw_ctrl[`BWU_CTRL_TMASK_MSB:`BWU_CTRL_TMASK_LSB];

  // ----------------------------------------------------------------
  // Instruction breakpoint
  // ----------------------------------------------------------------
  assign pc_equal = (pc_value == ib_addr);
  assign ib_cond = ib_ctrl[`BWU_CTRL_SEL_BIT] ? ~pc_equal : pc_equal;
  assign ib_hit = pc_valid & ib_ctrl[`BWU_CTRL_EN_BIT] & ib_cond
    & ib_tmask[pc_thread];

  // ----------------------------------------------------------------
  // Data watchpoint
  // ----------------------------------------------------------------
  assign dw_cond_a = (mem_addr >= dw_addr1);
  assign dw_cond_b = (mem_addr <= dw_addr2);
  assign dw_cond = dw_ctrl[`BWU_CTRL_SEL_BIT] ? (dw_cond_a | dw_cond_b)
    : (dw_cond_a & dw_cond_b);
  // Stores always compared, loads only on request
  assign dw_kind_ok = ~mem_is_load | dw_ctrl[`BWU_CTRL_LOAD_BIT];
  assign dw_hit = mem_valid & dw_kind_ok & dw_cond
    & dw_ctrl[`BWU_CTRL_EN_BIT] & dw_tmask[mem_thread];

  // ----------------------------------------------------------------
  // Resource watchpoint
  // ----------------------------------------------------------------
  assign res_masked = res_id & rw_mask;
  assign rw_cond = rw_ctrl[`BWU_CTRL_SEL_BIT] ? (res_masked != rw_value)
    : (res_masked == rw_value);
  assign rw_hit = res_valid & rw_cond & rw_ctrl[`BWU_CTRL_EN_BIT]
    & rw_tmask[res_thread];

endmodule // bwu_watch_slot
